//--- inc/rsq_pkg.sv
// shared constants, register layout and carrier types of the reset sequencer
package rsq_pkg;

  // ==========================================================
  // register map (byte addresses on the bus)
  localparam logic [31:0] OFF_RESET_CAUSE_AND_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFF_SEQ_STATUS = 32'h0000_0004;
  localparam logic [15:0] RESET_CAUSE_POR_VALUE = 16'h0003;
  // bits 13..9 are unimplemented and never store a one
  localparam logic [15:0] RESET_CAUSE_WRITE_MASK = 16'hc1ff;

  // ==========================================================
  // field positions of reset_cause_and_control
  localparam int BIT_TRAP_CONFLICT_FLAG = 15;
  localparam int BIT_BAD_OPCODE_OR_POINTER_FLAG = 14;
  localparam int BIT_REGULATOR_SLEEP_KEEP = 8;
  localparam int BIT_PIN_RESET_FLAG = 7;
  localparam int BIT_SOFT_RESET_FLAG = 6;
  localparam int BIT_SOFT_WATCHDOG_ENABLE = 5;
  localparam int BIT_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int BIT_SLEEP_FLAG = 3;
  localparam int BIT_IDLE_FLAG = 2;
  localparam int BIT_BROWNOUT_FLAG = 1;
  localparam int BIT_POWER_ON_FLAG = 0;

  // ==========================================================
  // field positions of the sequencer status word
  localparam int STS_SYS_RESET = 0;
  localparam int STS_CPU_RUN = 1;
  localparam int STS_CLOCK_READY = 2;
  localparam int STS_MONITOR_ACTIVE = 3;
  localparam int STS_FELL_BACK = 4;
  localparam int STS_OSC_LSB = 8;

  // ==========================================================
  // oscillator select codes
  localparam logic [2:0] OSC_FAST_RC = 3'h0;
  localparam logic [2:0] OSC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] OSC_EXT_CLOCK = 3'h2;
  localparam logic [2:0] OSC_EXT_CLOCK_PLL = 3'h3;
  localparam logic [2:0] OSC_CRYSTAL = 3'h4;
  localparam logic [2:0] OSC_CRYSTAL_PLL = 3'h5;
  localparam logic [2:0] OSC_SECONDARY = 3'h6;
  localparam logic [2:0] OSC_LOW_POWER_RC = 3'h7;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_POWER_ON_DELAY_NS = 10_000;
  localparam int T_START_DELAY_REG_NS = 20_000;
  localparam int T_START_DELAY_NOREG_NS = 64_000_000;
  localparam int T_STATE_RESET_NS = 20_000;
  localparam int T_PLL_LOCK_NS = 20_000;
  localparam int T_MONITOR_DELAY_NS = 100_000;
  localparam int OST_PERIODS = 1024;
  localparam int T_POWER_ON_DELAY_CYC = (T_POWER_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_START_DELAY_REG_CYC = (T_START_DELAY_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_START_DELAY_NOREG_CYC =
    (T_START_DELAY_NOREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_STATE_RESET_CYC = (T_STATE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_PLL_LOCK_CYC = (T_PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_MONITOR_DELAY_CYC = (T_MONITOR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } rsq_ahb_in_type;

  typedef struct packed {
    logic trap_conflict;
    logic bad_opcode_or_pointer;
    logic soft_reset;
    logic watchdog_timeout;
    logic sleep_enter;
    logic idle_enter;
    logic wake;
  } rsq_event_type;

  typedef struct packed {
    logic clk_switch_en;
    logic [2:0] cfg_initial_osc_select;
    logic cfg_watchdog_force;
    logic regulator_en;
    logic monitor_en;
  } rsq_cfg_type;

endpackage

//--- rtl/rsq_reset_sequencer.sv
// reset cause register, reset delay sequencing, clock release and clock monitor start
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
module rsq_reset_sequencer
  import rsq_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int START_DELAY_NOREG_CYC = T_START_DELAY_NOREG_CYC,
  parameter int MONITOR_DELAY_CYC = T_MONITOR_DELAY_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire rsq_pkg::rsq_ahb_in_type AHB_IN,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic BROWNOUT,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire rsq_pkg::rsq_event_type CORE_EVENTS,
  input wire rsq_pkg::rsq_cfg_type CFG,
  input wire logic [2:0] CURRENT_OSC_SELECT,
  input wire logic OSC_TICK,
  input wire logic CLOCK_VALID,
  output logic SYSTEM_RESET_N,
  output logic CPU_RUN,
  output logic [2:0] OSC_SELECT,
  output logic OSC_SELECT_LOAD,
  output logic MONITOR_ACTIVE,
  output logic CLOCK_FAIL_TRAP,
  output logic WATCHDOG_EN,
  output logic REGULATOR_SLEEP_KEEP
);
  import rsq_pkg::*;

  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN} rsq_seq_type;
  typedef enum logic [1:0] {KIND_POR, KIND_BOR, KIND_WARM} rsq_kind_type;
  typedef enum logic [1:0] {CLK_READY, CLK_OST, CLK_LOCK} rsq_clk_type;
  typedef enum logic [1:0] {MON_OFF, MON_WAIT, MON_ON} rsq_mon_type;

  // ==========================================================
  // pin synchronisers
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic tick_d_r;
  logic brownout_s;
  logic pin_reset_s;
  logic clock_valid_s;
  logic tick_s;
  logic tick_pulse;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      // the pin stages start at the idle high level so power-on never logs a pin reset
      sync1_r <= 4'h2;
      sync2_r <= 4'h2;
      tick_d_r <= 1'b0;
    end else begin
      sync1_r <= {OSC_TICK, CLOCK_VALID, MASTER_CLEAR_PIN_N, BROWNOUT};
      sync2_r <= sync1_r;
      tick_d_r <= sync2_r[3];
    end
  end

  assign brownout_s = sync2_r[0];
  // a low pin level is a reset request for as long as it is held
  assign pin_reset_s = ~sync2_r[1];
  assign clock_valid_s = sync2_r[2];
  assign tick_s = sync2_r[3];
  assign tick_pulse = tick_s & ~tick_d_r;

  // ==========================================================
  // reset sources
  logic any_source;
  logic sleep_or_idle;

  assign any_source = brownout_s | pin_reset_s | CORE_EVENTS.trap_conflict
                    | CORE_EVENTS.bad_opcode_or_pointer | CORE_EVENTS.soft_reset
                    | CORE_EVENTS.watchdog_timeout;
  assign sleep_or_idle = CORE_EVENTS.sleep_enter | CORE_EVENTS.idle_enter;

  // ==========================================================
  // bus slave: address phase capture
  logic wr_pend_r;
  logic wr_cause_r;
  logic rd_take;
  logic wr_take;
  logic [15:0] cause_r;
  logic [15:0] cause_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] status_word;

  assign rd_take = AHB_IN.hsel & AHB_IN.htrans[1] & AHB_IN.hready & ~AHB_IN.hwrite;
  assign wr_take = AHB_IN.hsel & AHB_IN.htrans[1] & AHB_IN.hready & AHB_IN.hwrite;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wr_pend_r <= 1'b0;
      wr_cause_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_take;
      wr_cause_r <= wr_take & (AHB_IN.haddr == OFF_RESET_CAUSE_AND_CONTROL);
    end
  end

  // read data is taken from the next value so a read right behind a write sees it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      if (AHB_IN.haddr == OFF_RESET_CAUSE_AND_CONTROL) begin
        hrdata_r <= {16'h0000, cause_nxt};
      end else if (AHB_IN.haddr == OFF_SEQ_STATUS) begin
        hrdata_r <= status_word;
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ==========================================================
  // reset cause and control register
  always_comb begin
    cause_nxt = cause_r;
    if (wr_pend_r && wr_cause_r) begin
      cause_nxt = AHB_IN.hwdata[15:0] & RESET_CAUSE_WRITE_MASK;
    end
    // hardware clears and the brown-out flag set come after the write, the other hardware sets last of all
    if (brownout_s) begin
      cause_nxt[BIT_TRAP_CONFLICT_FLAG] = 1'b0;
      cause_nxt[BIT_BAD_OPCODE_OR_POINTER_FLAG] = 1'b0;
      cause_nxt[BIT_SOFT_RESET_FLAG] = 1'b0;
      cause_nxt[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      cause_nxt[BIT_SLEEP_FLAG] = 1'b0;
      cause_nxt[BIT_IDLE_FLAG] = 1'b0;
      cause_nxt[BIT_BROWNOUT_FLAG] = 1'b1;
    end
    if (sleep_or_idle) begin
      cause_nxt[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
    end
    if (CORE_EVENTS.trap_conflict) begin
      cause_nxt[BIT_TRAP_CONFLICT_FLAG] = 1'b1;
    end
    if (CORE_EVENTS.bad_opcode_or_pointer) begin
      cause_nxt[BIT_BAD_OPCODE_OR_POINTER_FLAG] = 1'b1;
    end
    if (pin_reset_s) begin
      cause_nxt[BIT_PIN_RESET_FLAG] = 1'b1;
    end
    if (CORE_EVENTS.soft_reset) begin
      cause_nxt[BIT_SOFT_RESET_FLAG] = 1'b1;
    end
    if (CORE_EVENTS.watchdog_timeout) begin
      cause_nxt[BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
    end
    if (CORE_EVENTS.sleep_enter) begin
      cause_nxt[BIT_SLEEP_FLAG] = 1'b1;
    end
    if (CORE_EVENTS.idle_enter) begin
      cause_nxt[BIT_IDLE_FLAG] = 1'b1;
    end
  end

  // power-on is this block's own asynchronous reset
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cause_r <= RESET_CAUSE_POR_VALUE;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      WATCHDOG_EN <= 1'b0;
      REGULATOR_SLEEP_KEEP <= 1'b0;
    end else begin
      WATCHDOG_EN <= CFG.cfg_watchdog_force | cause_r[BIT_SOFT_WATCHDOG_ENABLE];
      REGULATOR_SLEEP_KEEP <= cause_r[BIT_REGULATOR_SLEEP_KEEP];
    end
  end

  // ==========================================================
  // system reset sequencer
  rsq_seq_type seq_r;
  rsq_kind_type kind_r;
  logic [CNT_W-1:0] delay_cnt_r;
  logic [CNT_W-1:0] start_cyc;
  logic [CNT_W-1:0] delay_load;
  logic system_reset_n_n_r;
  logic full_restart;

  assign start_cyc = CFG.regulator_en ? CNT_W'(T_START_DELAY_REG_CYC)
                                      : CNT_W'(START_DELAY_NOREG_CYC);
  assign full_restart = (kind_r != KIND_WARM);

  always_comb begin
    case (kind_r)
      KIND_POR: delay_load = CNT_W'(T_POWER_ON_DELAY_CYC) + start_cyc
                           + CNT_W'(T_STATE_RESET_CYC - 1);
      KIND_BOR: delay_load = start_cyc + CNT_W'(T_STATE_RESET_CYC - 1);
      default: delay_load = CNT_W'(T_STATE_RESET_CYC - 1);
    endcase
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      seq_r <= ST_HOLD;
      kind_r <= KIND_POR;
      delay_cnt_r <= '0;
      system_reset_n_n_r <= 1'b0;
    end else begin
      if (any_source) begin
        seq_r <= ST_HOLD;
        system_reset_n_n_r <= 1'b0;
        if (brownout_s) begin
          kind_r <= KIND_BOR;
        end else if (seq_r != ST_HOLD) begin
          kind_r <= KIND_WARM;
        end
      end else begin
        case (seq_r)
          ST_HOLD: begin
            seq_r <= ST_DELAY;
            delay_cnt_r <= delay_load;
          end
          ST_DELAY: begin
            if (delay_cnt_r == '0) begin
              seq_r <= ST_RUN;
              system_reset_n_n_r <= 1'b1;
            end else begin
              delay_cnt_r <= delay_cnt_r - 1'b1;
            end
          end
          ST_RUN: begin
            system_reset_n_n_r <= 1'b1;
          end
          default: begin
            seq_r <= ST_HOLD;
          end
        endcase
      end
    end
  end

  assign SYSTEM_RESET_N = system_reset_n_n_r;

  // ==========================================================
  // clock source selection and release
  rsq_clk_type clk_r;
  logic [2:0] osc_r;
  logic [2:0] osc_pick;
  logic [9:0] ost_cnt_r;
  logic [CNT_W-1:0] lock_cnt_r;
  logic osc_load_r;
  logic load_osc;
  logic fell_back_r;
  logic is_crystal;
  logic is_pll;

  assign load_osc = (seq_r == ST_HOLD) && !any_source;
  assign osc_pick = (full_restart || !CFG.clk_switch_en) ? CFG.cfg_initial_osc_select
                                                          : CURRENT_OSC_SELECT;
  assign is_crystal = (osc_pick == OSC_CRYSTAL) || (osc_pick == OSC_CRYSTAL_PLL)
                    || (osc_pick == OSC_SECONDARY);
  assign is_pll = (osc_pick == OSC_FAST_RC_PLL) || (osc_pick == OSC_EXT_CLOCK_PLL)
                || (osc_pick == OSC_CRYSTAL_PLL);

  // oscillator waits start with the reset delay and run beside it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      clk_r <= CLK_READY;
      osc_r <= OSC_FAST_RC;
      osc_load_r <= 1'b0;
      ost_cnt_r <= 10'h000;
      lock_cnt_r <= '0;
    end else begin
      osc_load_r <= load_osc;
      if (load_osc) begin
        osc_r <= osc_pick;
        ost_cnt_r <= 10'(OST_PERIODS - 1);
        lock_cnt_r <= CNT_W'(T_PLL_LOCK_CYC - 1);
        if (full_restart && is_crystal) begin
          clk_r <= CLK_OST;
        end else if (full_restart && is_pll) begin
          clk_r <= CLK_LOCK;
        end else begin
          clk_r <= CLK_READY;
        end
      end else if (fell_back_r && (osc_r != OSC_FAST_RC)) begin
        osc_r <= OSC_FAST_RC;
        clk_r <= CLK_READY;
      end else begin
        case (clk_r)
          CLK_OST: begin
            if (tick_pulse) begin
              if (ost_cnt_r == 10'h000) begin
                clk_r <= (osc_r == OSC_CRYSTAL_PLL) ? CLK_LOCK : CLK_READY;
              end else begin
                ost_cnt_r <= ost_cnt_r - 10'h001;
              end
            end
          end
          CLK_LOCK: begin
            if (lock_cnt_r == '0) begin
              clk_r <= CLK_READY;
            end else begin
              lock_cnt_r <= lock_cnt_r - 1'b1;
            end
          end
          CLK_READY: begin
            clk_r <= CLK_READY;
          end
          default: begin
            clk_r <= CLK_READY;
          end
        endcase
      end
    end
  end

  assign OSC_SELECT = osc_r;
  assign OSC_SELECT_LOAD = osc_load_r;

  // ==========================================================
  // wake hold and code execution gate
  logic [CNT_W-1:0] wake_cnt_r;
  logic cpu_run_r;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wake_cnt_r <= '0;
    end else if (CORE_EVENTS.wake && CFG.regulator_en) begin
      wake_cnt_r <= CNT_W'(T_START_DELAY_REG_CYC);
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cpu_run_r <= 1'b0;
    end else begin
      cpu_run_r <= system_reset_n_n_r && (clk_r == CLK_READY) && (wake_cnt_r == '0) && !any_source;
    end
  end

  assign CPU_RUN = cpu_run_r;

  // ==========================================================
  // clock fail monitor start
  rsq_mon_type mon_r;
  logic [CNT_W-1:0] mon_cnt_r;
  logic trap_r;
  logic slow_source;

  assign slow_source = (osc_r == OSC_CRYSTAL) || (osc_r == OSC_CRYSTAL_PLL)
                     || (osc_r == OSC_SECONDARY) || (osc_r == OSC_FAST_RC_PLL)
                     || (osc_r == OSC_EXT_CLOCK_PLL);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mon_r <= MON_OFF;
      mon_cnt_r <= '0;
      fell_back_r <= 1'b0;
      trap_r <= 1'b0;
    end else begin
      trap_r <= 1'b0;
      if (!system_reset_n_n_r) begin
        mon_r <= MON_OFF;
        if (seq_r == ST_HOLD && full_restart) begin
          fell_back_r <= 1'b0;
        end
      end else begin
        case (mon_r)
          MON_OFF: begin
            if (CFG.monitor_en) begin
              if (full_restart && slow_source) begin
                mon_r <= MON_WAIT;
                mon_cnt_r <= CNT_W'(MONITOR_DELAY_CYC - 1);
              end else begin
                mon_r <= MON_ON;
              end
            end
          end
          MON_WAIT: begin
            if (mon_cnt_r == '0) begin
              mon_r <= MON_ON;
            end else begin
              mon_cnt_r <= mon_cnt_r - 1'b1;
            end
          end
          MON_ON: begin
            // one fallback per power-on or brown-out restart; fast rc is then forced until the next one
            if (!clock_valid_s && !fell_back_r) begin
              fell_back_r <= 1'b1;
              trap_r <= 1'b1;
            end
          end
          default: begin
            mon_r <= MON_OFF;
          end
        endcase
      end
    end
  end

  assign MONITOR_ACTIVE = (mon_r == MON_ON);
  assign CLOCK_FAIL_TRAP = trap_r;

  // ==========================================================
  // status word
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_SYS_RESET] = ~system_reset_n_n_r;
    status_word[STS_CPU_RUN] = cpu_run_r;
    status_word[STS_CLOCK_READY] = (clk_r == CLK_READY);
    status_word[STS_MONITOR_ACTIVE] = (mon_r == MON_ON);
    status_word[STS_FELL_BACK] = fell_back_r;
    status_word[STS_OSC_LSB +: 3] = osc_r;
  end

endmodule // rsq_reset_sequencer

//--- testbench/rsq_checker_assertions.sv
// concurrent checks on the ports of the reset sequencer
module rsq_checker
  import rsq_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire rsq_pkg::rsq_event_type CORE_EVENTS,
  input wire rsq_pkg::rsq_cfg_type CFG,
  input wire logic SYSTEM_RESET_N,
  input wire logic CPU_RUN,
  input wire logic [2:0] OSC_SELECT,
  input wire logic OSC_SELECT_LOAD,
  input wire logic MONITOR_ACTIVE,
  input wire logic CLOCK_FAIL_TRAP,
  input wire logic WATCHDOG_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // ======
  // helpers
  // longest hold here is well below the counter range, so no saturation
  logic [15:0] low_cnt_r;
  wire logic src_w = CORE_EVENTS.trap_conflict | CORE_EVENTS.bad_opcode_or_pointer
    | CORE_EVENTS.soft_reset | CORE_EVENTS.watchdog_timeout;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      low_cnt_r <= 16'h0;
    end else if (SYSTEM_RESET_N) begin
      low_cnt_r <= 16'h0;
    end else begin
      low_cnt_r <= low_cnt_r + 16'h1;
    end
  end
  // ======
  // assertions
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not zero-wait okay");
  a_src_resets: assert property (src_w |=> !SYSTEM_RESET_N)
    else $error("reset source did not assert system reset");
  a_reset_long: assert property ($rose(SYSTEM_RESET_N) |-> low_cnt_r >= T_STATE_RESET_CYC)
    else $error("system reset released too early");
  a_cpu_drop: assert property ($fell(SYSTEM_RESET_N) |-> ##[0:1] !CPU_RUN)
    else $error("code kept running in system reset");
  a_cpu_gate: assert property ($rose(CPU_RUN) |-> SYSTEM_RESET_N)
    else $error("code started inside system reset");
  a_mon_start: assert property ($rose(MONITOR_ACTIVE) |-> SYSTEM_RESET_N)
    else $error("monitor started inside system reset");
  a_fallback_rc: assert property (CLOCK_FAIL_TRAP |=> OSC_SELECT == OSC_FAST_RC)
    else $error("no switch to fast rc after clock fail");
  a_trap_pulse: assert property (CLOCK_FAIL_TRAP |=> !CLOCK_FAIL_TRAP)
    else $error("clock fail trap longer than one cycle");
  a_wdog_force: assert property (CFG.cfg_watchdog_force |=> WATCHDOG_EN)
    else $error("forced watchdog not enabled");
  a_osc_load: assert property ($fell(SYSTEM_RESET_N) |-> ##[1:16] OSC_SELECT_LOAD)
    else $error("oscillator select not reloaded after reset");
  c_cpu_start: cover property ($rose(CPU_RUN));
  c_fallback: cover property (CLOCK_FAIL_TRAP);
  c_monitor: cover property ($rose(MONITOR_ACTIVE));
endmodule // rsq_checker

bind rsq_reset_sequencer rsq_checker i_rsq_checker (
  .CLK(CLK),
  .RESET(RESET),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .CORE_EVENTS(CORE_EVENTS),
  .CFG(CFG),
  .SYSTEM_RESET_N(SYSTEM_RESET_N),
  .CPU_RUN(CPU_RUN),
  .OSC_SELECT(OSC_SELECT),
  .OSC_SELECT_LOAD(OSC_SELECT_LOAD),
  .MONITOR_ACTIVE(MONITOR_ACTIVE),
  .CLOCK_FAIL_TRAP(CLOCK_FAIL_TRAP),
  .WATCHDOG_EN(WATCHDOG_EN)
);

//--- testbench/rsq_osc_model.sv
// oscillator partner: free-running tick and clock-good level
module rsq_osc_model #(
  parameter int HALF_NS = 13
) (
  input wire logic good,
  output logic tick,
  output logic valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // oscillator
  // a failed oscillator stops dead, so no stray periods reach the start-up counter
  initial begin
    tick = 1'b0;
    forever begin
      #(HALF_NS);
      tick = good ? ~tick : 1'b0;
    end
  end
  assign valid = good;
endmodule // rsq_osc_model

//--- testbench/rsq_reset_sequencer_bench.sv
// self-checking bench of the reset sequencer
module rsq_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rsq_pkg::*;
  localparam int NOREG_CYC = 100;
  localparam int MON_CYC = 50;
  localparam int OSC_HALF_NS = 13;
  localparam logic [31:0] RCA = OFF_RESET_CAUSE_AND_CONTROL;
  logic clk, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, brownout = 1'b0, pin_n = 1'b1;
  logic hreadyout, hresp, osc_good = 1'b1, tick, valid, sys_n, cpu_run, osc_load;
  logic mon_act, fail_trap, wdog_en, reg_keep, rd_ph = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [2:0] cur_osc = OSC_FAST_RC, osc_sel;
  rsq_event_type ev = '0;
  rsq_cfg_type cfg = {1'b1, OSC_CRYSTAL_PLL, 1'b0, 1'b1, 1'b1};
  rsq_ahb_in_type ahb;
  logic [31:0] exp_q[$];
  int n_fail = 0, n_tests = 0, n;
  int flag_bit[4] = '{BIT_TRAP_CONFLICT_FLAG, BIT_BAD_OPCODE_OR_POINTER_FLAG,
    BIT_SOFT_RESET_FLAG, BIT_WATCHDOG_TIMEOUT_FLAG};
  assign ahb = {hsel, haddr, htrans, hwrite, 3'h2, hreadyout, hwdata};

  rsq_reset_sequencer #(
    .START_DELAY_NOREG_CYC(NOREG_CYC),
    .MONITOR_DELAY_CYC(MON_CYC)
  ) i_rsq_reset_sequencer (
    .CLK(clk),
    .RESET(reset),
    .AHB_IN(ahb),
    .HRDATA(hrdata),
    .HREADYOUT(hreadyout),
    .HRESP(hresp),
    .BROWNOUT(brownout),
    .MASTER_CLEAR_PIN_N(pin_n),
    .CORE_EVENTS(ev),
    .CFG(cfg),
    .CURRENT_OSC_SELECT(cur_osc),
    .OSC_TICK(tick),
    .CLOCK_VALID(valid),
    .SYSTEM_RESET_N(sys_n),
    .CPU_RUN(cpu_run),
    .OSC_SELECT(osc_sel),
    .OSC_SELECT_LOAD(osc_load),
    .MONITOR_ACTIVE(mon_act),
    .CLOCK_FAIL_TRAP(fail_trap),
    .WATCHDOG_EN(wdog_en),
    .REGULATOR_SLEEP_KEEP(reg_keep)
  );
  rsq_osc_model #(.HALF_NS(OSC_HALF_NS)) i_rsq_osc_model (
    .good(osc_good),
    .tick(tick),
    .valid(valid)
  );

  // ======
  // clock, read-data scoreboard, watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_ph) begin
      check("read data", hrdata, exp_q.pop_front());
    end
    rd_ph <= hsel & htrans[1] & ~hwrite & hreadyout;
  end
  initial begin
    #(8 * 60000);
    n_fail++;
    give_verdict();
  end

  // ======
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic near(input string what, input int cnt, input int e);
    check(what, 32'(cnt >= e - 10 && cnt < e + 100), 32'h1);
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    exp_q.push_back({16'h0, e});
    bus(1'b0, a, $urandom);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    ev <= rsq_event_type'(e);
    @(posedge clk);
    ev <= '0;
  endtask
  // counts falling edges until the level is high; always lets one edge pass so an
  // output launched at the caller's edge is seen settled; the watchdog ends a hang
  task automatic wait_hi(ref logic s, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (s !== 1'b1 && cnt < 70000);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ======
  // tests
  initial begin
    void'($urandom(39425));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(RCA, 16'h0003);
    wait_hi(sys_n, n);
    near("power-on delay", n, T_POWER_ON_DELAY_CYC + T_START_DELAY_REG_CYC
      + T_STATE_RESET_CYC);
    wait_hi(mon_act, n);
    near("monitor delay", n, MON_CYC);
    check("power-on osc", osc_sel, OSC_CRYSTAL_PLL);
    $display("power-on test done");
    for (int i = 0; i < 4; i++) begin
      cfg.clk_switch_en <= ~i[0];
      cur_osc <= 3'($urandom_range(3));
      bus(1'b1, RCA, 32'h0);
      @(negedge clk);
      check("no reset on write", sys_n, 1'b1);
      pulse(7'h40 >> i);
      wait_hi(sys_n, n);
      near("warm delay", n, T_STATE_RESET_CYC);
      check("warm osc", osc_sel, i[0] ? OSC_CRYSTAL_PLL : cur_osc);
      rd(RCA, 16'h1 << flag_bit[i]);
    end
    cfg.clk_switch_en <= 1'b1;
    $display("event reset test done");
    fork
      bus(1'b1, RCA, 32'h0);
      begin
        repeat (2) @(posedge clk);
        ev <= rsq_event_type'(7'h40);
        @(posedge clk);
        ev <= '0;
      end
    join
    wait_hi(sys_n, n);
    rd(RCA, 16'h8000);
    bus(1'b1, RCA, 32'h0);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    wait_hi(sys_n, n);
    near("pin delay", n, T_STATE_RESET_CYC);
    rd(RCA, 16'h0080);
    $display("priority and pin test done");
    bus(1'b1, RCA, 32'h0000_ffff);
    rd(RCA, 16'hc1ff);
    rd(32'h0000_0010, 16'h0);
    check("regulator keep", reg_keep, 1'b1);
    check("watchdog by bit", wdog_en, 1'b1);
    cfg.regulator_en <= 1'b0;
    cur_osc <= OSC_EXT_CLOCK;
    brownout <= 1'b1;
    repeat (5) @(posedge clk);
    brownout <= 1'b0;
    wait_hi(sys_n, n);
    near("brown-out delay", n, NOREG_CYC + T_STATE_RESET_CYC);
    check("brown-out osc", osc_sel, OSC_CRYSTAL_PLL);
    wait_hi(cpu_run, n);
    near("osc and lock wait", n, OST_PERIODS * 2 * OSC_HALF_NS / CLK_PERIOD_NS
      + T_PLL_LOCK_CYC - NOREG_CYC - T_STATE_RESET_CYC);
    cfg.regulator_en <= 1'b1;
    rd(RCA, 16'h01a3);
    $display("brown-out test done");
    bus(1'b1, RCA, 32'h0000_0010);
    pulse(7'h04);
    rd(RCA, 16'h0008);
    pulse(7'h02);
    rd(RCA, 16'h000c);
    check("watchdog off", wdog_en, 1'b0);
    cfg.cfg_watchdog_force <= 1'b1;
    repeat (2) @(negedge clk);
    check("watchdog forced", wdog_en, 1'b1);
    wait_hi(cpu_run, n);
    pulse(7'h01);
    @(negedge clk);
    wait_hi(cpu_run, n);
    near("wake delay", n, T_START_DELAY_REG_CYC);
    $display("power-save test done");
    osc_good <= 1'b0;
    pulse(7'h10);
    wait_hi(fail_trap, n);
    @(negedge clk);
    check("fallback osc", osc_sel, OSC_FAST_RC);
    rd(OFF_SEQ_STATUS, 16'h001e);
    osc_good <= 1'b1;
    $display("clock fail test done");
    give_verdict();
  end
endmodule // rsq_reset_sequencer_bench
